// File: verif/rsv_mcu_model.sv
/*
  Microcontroller side of the reset line with its pull-up resistor.
  Assumes the supervisor drives only while pulling low.
*/
`timescale 1ns/1ps
`default_nettype none

module rsv_mcu_model (
  input  wire logic reset_out_n_o,
  input  wire logic reset_out_n_oe,
  output logic      reset_line_n
);
  // Released line is pulled high, never left floating
  assign reset_line_n = reset_out_n_oe ? reset_out_n_o : 1'b1;
endmodule : rsv_mcu_model

`default_nettype wire

// File: verif/rsv_supervisor_sva.sv
/*
  Port assertions and covers for the reset supervisor.
  Assumes clk_en is only dropped while the reset line is steady;
  the helper counters ignore it.
*/
`timescale 1ns/1ps
`default_nettype none

module rsv_supervisor_sva (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      clk_en,
  input wire logic [rsv_pkg::LVL_W-1:0] feedback_level,
  input wire logic                      reset_out_n_in,
  input wire logic                      reset_out_n_o,
  input wire logic                      reset_out_n_oe,
  input wire logic                      reset_line_seen,
  input wire logic                      uv_fault,
  input wire logic                      ov_fault,
  input wire logic                      setting_latched
);
  logic [9:0] raw_cnt;
  logic [1:0] rel_cnt;
  // Tight band: highest undervoltage threshold, so a real fault always counts here
  wire logic raw = feedback_level > 11'h42E || feedback_level < 11'h398;

  always_ff @(posedge clk) begin
    if (rst) begin
      raw_cnt <= 10'h000;
      rel_cnt <= 2'h0;
    end else begin
      raw_cnt <= !raw ? 10'h000 : raw_cnt + {9'h000, raw_cnt != 10'h3FF};
      rel_cnt <= rel_cnt + {1'b0, rel_cnt != 2'h3};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rst_state_a: assert property (disable iff (1'b0) rst |=>
    reset_out_n_oe && !setting_latched && !uv_fault && !ov_fault)
    else $error("reset state wrong");
  od_pair_a: assert property (reset_out_n_o != reset_out_n_oe)
    else $error("output value and enable disagree");
  blank_min_a: assert property ($rose(reset_out_n_oe) |->
    raw_cnt >= 10'h271) else $error("fault shorter than blanking");
  ov_cause_a: assert property ($rose(ov_fault) |->
    $past(feedback_level) > 11'h42E) else $error("overvoltage flag early");
  uv_cause_a: assert property ($rose(uv_fault) |->
    $past(feedback_level) < 11'h398) else $error("undervoltage flag early");
  flag_low_a: assert property ((uv_fault || ov_fault) |->
    reset_out_n_oe) else $error("flag set with output released");
  release_band_a: assert property ($fell(reset_out_n_oe) |->
    $past(feedback_level) < 11'h424 && $past(feedback_level) > 11'h262)
    else $error("release outside band");
  latch_a: assert property ((clk_en || setting_latched) |=>
    setting_latched) else $error("setting not latched");
  line_sync_a: assert property (rel_cnt == 2'h3 |->
    reset_line_seen == $past(reset_out_n_in, 2))
    else $error("line level not seen");

  cover property ($rose(ov_fault));
  cover property ($rose(uv_fault));
  cover property ($fell(reset_out_n_oe));
endmodule : rsv_supervisor_sva

`default_nettype wire

// File: verif/rsv_supervisor_tb_top.sv
/*
  Self-checking bench: every setting code, blanking, under- and
  overvoltage release, restart of recovery, clock-enable freeze.
  Short delay parameters.
  Assumes the design and package files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module rsv_supervisor_tb_top;
  localparam int PON [4] = '{30, 40, 50, 60};
  localparam int FRD [4] = '{20, 24, 800, 32};
  localparam int DOF [16] = '{0,0,0,0,1,1,1,1,2,2,2,3,3,2,2,2};
  localparam int UOF [16] = '{0,1,2,3,0,1,2,3,1,2,3,0,1,0,0,0};
  localparam int UVT [4] = '{920, 860, 750, 600};
  logic        clk = 1'b0;
  logic        rst, clk_en = 1'b1, soft_start_done, reset_out_n_in;
  logic [10:0] feedback_level;
  logic [3:0]  delay_select_pin;
  logic        reset_out_n_o, reset_out_n_oe, reset_line_seen;
  logic        uv_fault, ov_fault, setting_latched;
  int          failures = 0, check_count = 0, cycles = 0;

  rsv_supervisor #(.PON_CYC_0(PON[0]), .PON_CYC_1(PON[1]),
    .PON_CYC_2(PON[2]), .PON_CYC_3(PON[3]), .FRD_CYC_0(FRD[0]),
    .FRD_CYC_1(FRD[1]), .FRD_CYC_2(FRD[2]), .FRD_CYC_3(FRD[3]))
    i_dut (.clk, .rst, .clk_en, .soft_start_done,
    .feedback_level, .delay_select_pin, .reset_out_n_in, .reset_out_n_o,
    .reset_out_n_oe, .reset_line_seen, .uv_fault, .ov_fault,
    .setting_latched);
  rsv_mcu_model i_mcu (.reset_out_n_o, .reset_out_n_oe,
    .reset_line_n(reset_out_n_in));

  always #4 clk = ~clk;

  task automatic end_of_test;
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %0h, expected %0h", $time, got, exp);
    end
  endtask : chk

  // Apply a level for n edges; the output must not move meanwhile
  task automatic hold(input int v, input int n);
    logic was;
    was = reset_out_n_oe;
    feedback_level = 11'(v);
    repeat (n) begin
      @(posedge clk);
      #1;
      if (reset_out_n_oe !== was) chk(reset_out_n_oe, was);
    end
    chk(reset_out_n_oe, was);
  endtask : hold

  // Apply a level, count edges until the enable reads want
  task automatic step(input int v, input logic want, input int exp);
    int k;
    feedback_level = 11'(v);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (reset_out_n_oe !== want && k < exp + 5);
    chk(k, exp);
  endtask : step

  task automatic run_code(input int c);
    int u;
    u = UVT[UOF[c]];
    rst = 1'b1;
    soft_start_done = 1'b0;
    feedback_level = 11'h000;
    delay_select_pin = 4'(c);
    repeat (6) @(posedge clk);
    #1;
    chk(reset_out_n_oe, 1'b1);
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    delay_select_pin = ~delay_select_pin;
    chk(setting_latched, 1'b1);
    feedback_level = 11'h3E8;
    soft_start_done = 1'b1;
    step(1000, 1'b0, PON[DOF[c]] + 2);
    hold(u, 700);
    chk(reset_line_seen, 1'b1);
    hold(u - 1, 625);
    hold(1000, 2);
    step(u - 1, 1'b1, 626);
    chk(uv_fault, 1'b1);
    hold(u + 10, 50);
    step(u + 11, 1'b0, FRD[DOF[c]] + 2);
    chk(uv_fault, 1'b0);
  endtask : run_code

  // Long recovery so a fault can be filtered before it expires
  task automatic ov_case;
    hold(1070, 700);
    step(1071, 1'b1, 626);
    chk(ov_fault, 1'b1);
    hold(1060, 50);
    hold(1059, 50);
    hold(1071, 626);
    step(1059, 1'b0, 802);
    chk(ov_fault, 1'b0);
  endtask : ov_case

  // A low enable must freeze the blanking count, so no fault while frozen
  task automatic freeze_case;
    hold(1071, 300);
    clk_en = 1'b0;
    hold(1071, 400);
    clk_en = 1'b1;
    step(1071, 1'b1, 326);
    chk(ov_fault, 1'b1);
  endtask : freeze_case

  initial begin
    for (int c = 0; c < 16; c++) begin
      run_code(c);
    end
    ov_case();
    freeze_case();
    end_of_test();
  end
endmodule : rsv_supervisor_tb_top

bind rsv_supervisor rsv_supervisor_sva i_sva (.clk, .rst, .clk_en,
  .feedback_level, .reset_out_n_in, .reset_out_n_o, .reset_out_n_oe,
  .reset_line_seen, .uv_fault, .ov_fault, .setting_latched);

`default_nettype wire

// File: verilog/rsv_delay_if.sv
/*
  Carrier between the supervisor and its delay timer.
  Assumes both ends share one clock and clock enable.
*/
`timescale 1ns/1ps
`default_nettype none

interface rsv_delay_if #(
  parameter int CNT_W = 21
);
  logic             start;
  logic [CNT_W-1:0] load;
  logic             done;

  modport ctrl  (output start, output load, input done);
  modport timer (input start, input load, output done);
endinterface : rsv_delay_if

`default_nettype wire

// File: verilog/rsv_delay_timer.sv
/*
  Down-counting release delay timer; a start reloads it with the load value.
  Assumes start and load come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module rsv_delay_timer #(
  parameter int CNT_W = 21
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clk_en,
  rsv_delay_if.timer t
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } rsv_tmr_state_t;

  rsv_tmr_state_t q_reg;
  rsv_tmr_state_t q_next;

  always_comb begin
    q_next      = q_reg;
    q_next.done = 1'b0;
    if (t.start) begin
      // A new start discards any delay in flight
      q_next.cnt = t.load;
    end else if (q_reg.cnt != '0) begin
      q_next.cnt = q_reg.cnt - CNT_W'(1);
      if (q_reg.cnt == CNT_W'(1)) begin
        q_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= '0;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  assign t.done = q_reg.done;

endmodule : rsv_delay_timer

`default_nettype wire

// File: verilog/rsv_pkg.sv
/*
  Shared constants, types and lookups for the output voltage reset
  supervisor: thresholds in per-mille of nominal, delay times, setting
  decode and state encoding.
  Assumes a single 125 MHz clock and a feedback sample in per-mille units.
*/
`default_nettype none

package rsv_pkg;

  localparam int CLK_MHZ   = 125;
  localparam int NS_PER_US = 1000;

  // Feedback level: per-mille of the nominal output
  localparam int LVL_W = 11;
  localparam logic [LVL_W-1:0] LVL_NOMINAL = 11'h3E8;
  localparam logic [LVL_W-1:0] OV_TH       = 11'h42E;
  localparam logic [LVL_W-1:0] OV_HYS      = 11'h00A;
  localparam logic [LVL_W-1:0] UV_HYS      = 11'h00A;
  localparam logic [LVL_W-1:0] UV_TH_8     = 11'h398;
  localparam logic [LVL_W-1:0] UV_TH_14    = 11'h35C;
  localparam logic [LVL_W-1:0] UV_TH_25    = 11'h2EE;
  localparam logic [LVL_W-1:0] UV_TH_40    = 11'h258;

  // Delay times in ns, as printed
  localparam longint PON_NS_0 = 60000;
  localparam longint PON_NS_1 = 1900000;
  localparam longint PON_NS_2 = 7700000;
  localparam longint PON_NS_3 = 15400000;
  localparam longint FRD_NS_0 = 30000;
  localparam longint FRD_NS_1 = 1300000;
  localparam longint FRD_NS_2 = 5100000;
  localparam longint FRD_NS_3 = 10200000;
  localparam longint BLANK_NS = 5000;

  // Least time: round up, never below one cycle
  function automatic int ns_to_cyc(longint ns);
    longint c;
    c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    if (c < 1) begin
      c = 1;
    end
    return int'(c);
  endfunction : ns_to_cyc

  localparam int CNT_W   = 21;
  localparam int BLANK_W = 10;
  localparam logic [BLANK_W-1:0] BLANK_CYC = BLANK_W'(ns_to_cyc(BLANK_NS));

  localparam int SEL_W = 4;

  // Setting code to {delay pair index, undervoltage index}
  function automatic logic [3:0] decode_setting(logic [SEL_W-1:0] code);
    logic [3:0] r;
    r = 4'h8;
    unique case (code)
      4'h0:    r = 4'h0;
      4'h1:    r = 4'h1;
      4'h2:    r = 4'h2;
      4'h3:    r = 4'h3;
      4'h4:    r = 4'h4;
      4'h5:    r = 4'h5;
      4'h6:    r = 4'h6;
      4'h7:    r = 4'h7;
      4'h8:    r = 4'h9;
      4'h9:    r = 4'hA;
      4'hA:    r = 4'hB;
      4'hB:    r = 4'hC;
      4'hC:    r = 4'hD;
      default: r = 4'h8;
    endcase
    return r;
  endfunction : decode_setting

  function automatic logic [LVL_W-1:0] uv_threshold(logic [1:0] idx);
    logic [LVL_W-1:0] t;
    t = UV_TH_8;
    unique case (idx)
      2'h0: t = UV_TH_8;
      2'h1: t = UV_TH_14;
      2'h2: t = UV_TH_25;
      2'h3: t = UV_TH_40;
    endcase
    return t;
  endfunction : uv_threshold

  typedef enum logic [2:0] {
    ST_INIT,
    ST_WAIT_SS,
    ST_PON,
    ST_OK,
    ST_FAULT,
    ST_REC
  } rsv_state_t;

endpackage : rsv_pkg

`default_nettype wire

// File: verilog/rsv_supervisor.sv
/*
  Output voltage reset supervisor: blanking filter on the under- and
  overvoltage compare, setting latch, power-on and fault-recovery release
  delays, and the open-drain active-low reset output.
  Assumes feedback_level and delay_select_pin are produced by converter
  logic on clk; soft_start_done is a level from the same domain.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - Reset high in range, low outside
// R2 - After soft-start, wait power-on delay, release
// R3 - Below undervoltage threshold forces reset low
// R4 - Above undervoltage plus hysteresis, release after recovery
// R5 - Overvoltage handled like undervoltage, recovery delay
// R6 - Below overvoltage minus hysteresis, release after recovery
// R7 - Only faults longer than blanking pull low
// R8 - Setting latched once at initialization
// R9 - Overvoltage threshold fixed, setting independent
// R10 - Grounded pin: 0.06/0.03 ms, -8 percent
// R11 - Open pin: 7.7/5.1 ms, -8 percent
// R12 - Fourteen settings decode to delays and thresholds
// R13 - Supervision always active while operating
// R14 - Overvoltage flagged about 7 percent above nominal
// R15 - Reset low from power-up until power-on delay
// R16 - New fault restarts recovery delay from zero
module rsv_supervisor #(
  parameter int PON_CYC_0 = rsv_pkg::ns_to_cyc(rsv_pkg::PON_NS_0),
  parameter int PON_CYC_1 = rsv_pkg::ns_to_cyc(rsv_pkg::PON_NS_1),
  parameter int PON_CYC_2 = rsv_pkg::ns_to_cyc(rsv_pkg::PON_NS_2),
  parameter int PON_CYC_3 = rsv_pkg::ns_to_cyc(rsv_pkg::PON_NS_3),
  parameter int FRD_CYC_0 = rsv_pkg::ns_to_cyc(rsv_pkg::FRD_NS_0),
  parameter int FRD_CYC_1 = rsv_pkg::ns_to_cyc(rsv_pkg::FRD_NS_1),
  parameter int FRD_CYC_2 = rsv_pkg::ns_to_cyc(rsv_pkg::FRD_NS_2),
  parameter int FRD_CYC_3 = rsv_pkg::ns_to_cyc(rsv_pkg::FRD_NS_3)
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  input  wire logic                          soft_start_done,
  input  wire logic [rsv_pkg::LVL_W-1:0]     feedback_level,
  input  wire logic [rsv_pkg::SEL_W-1:0]     delay_select_pin,
  input  wire logic                          reset_out_n_in,
  output logic                               reset_out_n_o,
  output logic                               reset_out_n_oe,
  output logic                               reset_line_seen,
  output logic                               uv_fault,
  output logic                               ov_fault,
  output logic                               setting_latched
);

  localparam int CNT_W = rsv_pkg::CNT_W;

  typedef struct packed {
    rsv_pkg::rsv_state_t             st;
    logic [1:0]                      dly_idx;
    logic [1:0]                      uv_idx;
    logic [rsv_pkg::BLANK_W-1:0]     blank_cnt;
    logic                            out_low;
    logic                            uv_seen;
    logic                            ov_seen;
    logic                            latched;
    logic                            pin_s1;
    logic                            pin_s2;
  } rsv_sup_state_t;

  localparam rsv_sup_state_t RST_STATE = '{
    st:        rsv_pkg::ST_INIT,
    dly_idx:   2'h0,
    uv_idx:    2'h0,
    blank_cnt: '0,
    out_low:   1'b1,
    uv_seen:   1'b0,
    ov_seen:   1'b0,
    latched:   1'b0,
    pin_s1:    1'b1,
    pin_s2:    1'b1
  };

  rsv_sup_state_t q_reg;
  rsv_sup_state_t q_next;

  rsv_delay_if #(.CNT_W(CNT_W)) dly_if ();

  rsv_delay_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clk    (clk),
    .rst    (rst),
    .clk_en (clk_en),
    .t      (dly_if.timer)
  );

  function automatic logic [CNT_W-1:0] pon_cycles(logic [1:0] idx);
    logic [CNT_W-1:0] c;
    c = CNT_W'(PON_CYC_0);
    unique case (idx)
      2'h0: c = CNT_W'(PON_CYC_0);
      2'h1: c = CNT_W'(PON_CYC_1);
      2'h2: c = CNT_W'(PON_CYC_2);
      2'h3: c = CNT_W'(PON_CYC_3);
    endcase
    return c;
  endfunction : pon_cycles

  function automatic logic [CNT_W-1:0] frd_cycles(logic [1:0] idx);
    logic [CNT_W-1:0] c;
    c = CNT_W'(FRD_CYC_0);
    unique case (idx)
      2'h0: c = CNT_W'(FRD_CYC_0);
      2'h1: c = CNT_W'(FRD_CYC_1);
      2'h2: c = CNT_W'(FRD_CYC_2);
      2'h3: c = CNT_W'(FRD_CYC_3);
    endcase
    return c;
  endfunction : frd_cycles

  logic [rsv_pkg::LVL_W-1:0] uv_th;
  logic [rsv_pkg::LVL_W-1:0] uv_release;
  logic [rsv_pkg::LVL_W-1:0] ov_release;
  logic                      raw_uv;
  logic                      raw_ov;
  logic                      fault_f;
  logic                      in_band;
  logic [3:0]                dec;

  always_comb begin
    q_next       = q_reg;
    dly_if.start = 1'b0;
    dly_if.load  = '0;
    dec          = rsv_pkg::decode_setting(delay_select_pin); // [R10] [R11] [R12]

    q_next.pin_s1 = reset_out_n_in;
    q_next.pin_s2 = q_reg.pin_s1;

    // Compare against the latched threshold; overvoltage is fixed
    uv_th      = rsv_pkg::uv_threshold(q_reg.uv_idx);
    uv_release = uv_th + rsv_pkg::UV_HYS;
    ov_release = rsv_pkg::OV_TH - rsv_pkg::OV_HYS;
    raw_uv     = feedback_level < uv_th;              // [R3]
    raw_ov     = feedback_level > rsv_pkg::OV_TH;     // [R9] [R14]
    in_band    = (feedback_level > uv_release) &&
                 (feedback_level < ov_release);       // [R4] [R6]

    // Saturating blanking counter; any gap restarts it
    if (raw_uv || raw_ov) begin
      if (q_reg.blank_cnt != rsv_pkg::BLANK_CYC) begin
        q_next.blank_cnt = q_reg.blank_cnt + rsv_pkg::BLANK_W'(1);
      end
    end else begin
      q_next.blank_cnt = '0;
    end
    // The condition must still be present when the count is full,
    // otherwise an excursion of exactly the blanking time would trip
    fault_f = (raw_uv || raw_ov) &&
              (q_reg.blank_cnt == rsv_pkg::BLANK_CYC); // [R7]

    unique case (q_reg.st)
      rsv_pkg::ST_INIT: begin
        // The setting is taken once and never again
        q_next.dly_idx = dec[3:2];                    // [R8]
        q_next.uv_idx  = dec[1:0];                    // [R8]
        q_next.latched = 1'b1;
        q_next.st      = rsv_pkg::ST_WAIT_SS;
      end
      rsv_pkg::ST_WAIT_SS: begin
        // Comparators are ignored until soft-start is done
        q_next.blank_cnt = '0;                        // [R15]
        if (soft_start_done) begin                    // [R15]
          dly_if.start = 1'b1;
          dly_if.load  = pon_cycles(q_reg.dly_idx);   // [R2]
          q_next.st    = rsv_pkg::ST_PON;
        end
      end
      rsv_pkg::ST_PON: begin
        if (fault_f) begin
          q_next.st = rsv_pkg::ST_FAULT;
        end else if (dly_if.done) begin
          q_next.st = rsv_pkg::ST_OK;                 // [R2]
        end
      end
      rsv_pkg::ST_OK: begin
        if (fault_f) begin
          q_next.st = rsv_pkg::ST_FAULT;              // [R3] [R5] [R13]
        end
      end
      rsv_pkg::ST_FAULT: begin
        if (in_band) begin
          dly_if.start = 1'b1;
          dly_if.load  = frd_cycles(q_reg.dly_idx);   // [R4] [R5] [R6]
          q_next.st    = rsv_pkg::ST_REC;
        end
      end
      rsv_pkg::ST_REC: begin
        // A fresh fault abandons the delay; the next entry reloads it
        if (fault_f) begin
          q_next.st = rsv_pkg::ST_FAULT;              // [R16]
        end else if (dly_if.done) begin
          q_next.st = rsv_pkg::ST_OK;                 // [R4] [R6]
        end
      end
      default: begin
        q_next.st = rsv_pkg::ST_INIT;
      end
    endcase

    // Cause flags show the last filtered fault until release
    if (fault_f && q_reg.st != rsv_pkg::ST_WAIT_SS &&
        q_reg.st != rsv_pkg::ST_INIT) begin
      q_next.uv_seen = raw_uv;
      q_next.ov_seen = raw_ov;
    end else if (q_next.st == rsv_pkg::ST_OK) begin
      q_next.uv_seen = 1'b0;
      q_next.ov_seen = 1'b0;
    end

    q_next.out_low = q_next.st != rsv_pkg::ST_OK;     // [R1] [R15]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= RST_STATE;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  // Open drain: only ever pulls low
  assign reset_out_n_o   = ~q_reg.out_low;            // [R1]
  assign reset_out_n_oe  = q_reg.out_low;             // [R1]
  assign reset_line_seen = q_reg.pin_s2;
  assign uv_fault        = q_reg.uv_seen;
  assign ov_fault        = q_reg.ov_seen;
  assign setting_latched = q_reg.latched;

endmodule : rsv_supervisor

`default_nettype wire
